// ===== hw/sec_pkg.sv
// Shared constants and state types of the serial EEPROM command port
package sec_pkg;
    localparam int         ADDR_W          = 11;
    localparam int         WORD_W          = 16;
    localparam int         MEM_DEPTH       = 1024;
    localparam int         WADDR_W         = 10;
    localparam int         HDR_W           = 13;
    localparam logic [4:0] HDR_LAST_X16    = 5'h0B;
    localparam logic [4:0] HDR_LAST_X8     = 5'h0C;
    localparam logic [4:0] DATA_LAST_X16   = 5'h0F;
    localparam logic [4:0] DATA_LAST_X8    = 5'h07;
    localparam logic [3:0] RD_LAST_X16     = 4'hF;
    localparam logic [3:0] RD_LAST_X8      = 4'h7;
    localparam logic [1:0] OP_SPECIAL      = 2'h0;
    localparam logic [1:0] OP_WRITE        = 2'h1;
    localparam logic [1:0] OP_READ         = 2'h2;
    localparam logic [1:0] OP_ERASE        = 2'h3;
    localparam logic [1:0] MODE_DISABLE    = 2'h0;
    localparam logic [1:0] MODE_FILL       = 2'h1;
    localparam logic [1:0] MODE_CLEAR      = 2'h2;
    localparam logic [1:0] MODE_ENABLE     = 2'h3;
    localparam logic [15:0] ERASED_WORD    = 16'hFFFF;
    localparam logic [9:0] LAST_WADDR      = 10'h3FF;
    localparam int         PROG_TIME_MS    = 10;
    localparam int         CLK_FREQ_KHZ    = 200000;
    localparam int         PROG_CYCLES     = PROG_TIME_MS * CLK_FREQ_KHZ;

    typedef enum logic [4:0] {
        LK_IDLE = 5'h01,
        LK_HDR  = 5'h02,
        LK_DATA = 5'h04,
        LK_READ = 5'h08,
        LK_DONE = 5'h10
    } sec_link_st_t;

    typedef enum logic [2:0] {
        CO_IDLE  = 3'h1,
        CO_ARMED = 3'h2,
        CO_BUSY  = 3'h4
    } sec_core_st_t;
endpackage : sec_pkg

// ===== hw/sec_mem.sv
// Word array with byte writes on the core clock and a registered read on the link clock
`timescale 1ns/1ps
module sec_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 1024,
    parameter int AW    = 10
) (
    input  wire logic             i_wr_clock,
    input  wire logic             i_wr_en,
    input  wire logic [AW-1:0]    i_wr_addr,
    input  wire logic [1:0]       i_wr_be,
    input  wire logic [WIDTH-1:0] i_wr_data,
    input  wire logic             i_rd_clock,
    input  wire logic             i_rd_en,
    input  wire logic [AW-1:0]    i_rd_addr,
    output logic      [WIDTH-1:0] o_rd_data
);
    logic [WIDTH-1:0] mem_ff [DEPTH];

    // Reads never overlap a programming cycle in normal use, so no crossing guard here
    always_ff @(posedge i_wr_clock) begin
        if (i_wr_en && i_wr_be[1]) begin
            mem_ff[i_wr_addr][WIDTH-1:WIDTH/2] <= i_wr_data[WIDTH-1:WIDTH/2];
        end
        if (i_wr_en && i_wr_be[0]) begin
            mem_ff[i_wr_addr][WIDTH/2-1:0] <= i_wr_data[WIDTH/2-1:0];
        end
    end

    always_ff @(posedge i_rd_clock) begin
        if (i_rd_en) begin
            o_rd_data <= mem_ff[i_rd_addr];
        end
    end
endmodule : sec_mem

// ===== hw/sec_command_port.sv
// Three-wire serial command port of a 16-kbit serial EEPROM
`timescale 1ns/1ps
module sec_command_port
    import sec_pkg::*;
#(
    parameter int PROG_CYCLES_P = PROG_CYCLES
) (
    input  wire logic i_clock,
    input  wire logic i_srst,
    input  wire logic i_serial_shift_clock,
    input  wire logic i_chip_select,
    input  wire logic i_serial_in,
    input  wire logic i_write_protect_n,
    input  wire logic i_word_width_select,
    output logic      o_serial_out,
    output logic      o_serial_out_en,
    output logic      o_busy,
    output logic      o_standby,
    output logic      o_program_enabled
);
    function automatic logic [1:0] f_op(input logic [HDR_W-1:0] h, input logic word_width_select);
        f_op = word_width_select ? h[11:10] : h[12:11];
    endfunction : f_op

    function automatic logic [ADDR_W-1:0] f_addr(input logic [HDR_W-1:0] h, input logic word_width_select);
        f_addr = word_width_select ? {1'b0, h[9:0]} : h[10:0];
    endfunction : f_addr

    function automatic logic [1:0] f_mode(input logic [ADDR_W-1:0] a, input logic word_width_select);
        f_mode = word_width_select ? a[9:8] : a[10:9];
    endfunction : f_mode

    // ---------------- Link domain (shift clock) ----------------
    logic               link_rst_ff;
    logic               frame_rst;
    sec_link_st_t       lk_st_ff;
    logic [4:0]         cnt_ff;
    logic [11:0]        hdr_sr_ff;
    logic [14:0]        data_sr_ff;
    logic [ADDR_W-1:0]  rd_ptr_ff;
    logic [3:0]         rd_idx_ff;
    logic               dout_ff;
    logic               rd_act_ff;
    logic               started_ff;
    logic [1:0]         org_sync_ff;
    logic               cmd_tgl_ff;
    logic [1:0]         cmd_op_ff;
    logic [ADDR_W-1:0]  cmd_addr_ff;
    logic [WORD_W-1:0]  cmd_data_ff;
    logic               cmd_org_ff;
    logic [WORD_W-1:0]  rd_q;
    logic [HDR_W-1:0]   full_hdr;
    logic               lorg;
    logic               hdr_last;
    logic               data_last;
    logic               idx_last;
    logic [1:0]         hdr_op;
    logic [ADDR_W-1:0]  hdr_addr;
    logic               mem_rd_en;
    logic [ADDR_W-1:0]  nxt_rd_ptr;
    logic [WORD_W-1:0]  sel_word;

    // Deselect clears the frame asynchronously, because the shift clock may not run again
    assign frame_rst = link_rst_ff | ~i_chip_select;
    assign lorg      = org_sync_ff[1];
    assign full_hdr  = {hdr_sr_ff, i_serial_in};
    assign hdr_op    = f_op(full_hdr, lorg);
    assign hdr_addr  = f_addr(full_hdr, lorg);
    assign hdr_last  = (cnt_ff == (lorg ? HDR_LAST_X16 : HDR_LAST_X8));
    assign data_last = (cnt_ff == (lorg ? DATA_LAST_X16 : DATA_LAST_X8));
    assign idx_last  = (rd_idx_ff == (lorg ? RD_LAST_X16 : RD_LAST_X8));
    assign mem_rd_en = ((lk_st_ff == LK_HDR) && hdr_last && (hdr_op == OP_READ))
                     || ((lk_st_ff == LK_READ) && idx_last);
    // Halfword wrap keeps the pointer inside 1024 words
    assign nxt_rd_ptr = (lk_st_ff == LK_HDR) ? hdr_addr :
                        lorg ? {1'b0, rd_ptr_ff[9:0] + 10'h001} :
                               rd_ptr_ff + 11'h001;
    // Byte address 0 of a word is its upper byte
    assign sel_word  = lorg ? rd_q : {(rd_ptr_ff[0] ? rd_q[7:0] : rd_q[15:8]), 8'h00};

    // Width strap is static; reset value selects halfword as the pull-up would
    always_ff @(posedge i_serial_shift_clock or posedge link_rst_ff) begin
        if (link_rst_ff) begin
            org_sync_ff <= 2'h3;
        end else begin
            org_sync_ff <= {org_sync_ff[0], i_word_width_select};
        end
    end

    always_ff @(posedge i_serial_shift_clock or posedge frame_rst) begin
        if (frame_rst) begin
            lk_st_ff   <= LK_IDLE;
            cnt_ff     <= 5'h00;
            hdr_sr_ff  <= 12'h000;
            data_sr_ff <= 15'h0000;
            rd_ptr_ff  <= 11'h000;
            rd_idx_ff  <= 4'h0;
            dout_ff    <= 1'b0;
            rd_act_ff  <= 1'b0;
            started_ff <= 1'b0;
        end else begin
            case (lk_st_ff)
                LK_IDLE: begin
                    if (i_serial_in) begin
                        lk_st_ff   <= LK_HDR;
                        started_ff <= 1'b1;
                        cnt_ff     <= 5'h00;
                    end
                end
                LK_HDR: begin
                    hdr_sr_ff <= full_hdr[11:0];
                    cnt_ff    <= cnt_ff + 5'h01;
                    if (hdr_last) begin
                        cnt_ff <= 5'h00;
                        if (hdr_op == OP_READ) begin
                            lk_st_ff  <= LK_READ;
                            rd_ptr_ff <= hdr_addr;
                            rd_idx_ff <= 4'h0;
                            dout_ff   <= 1'b0;
                            rd_act_ff <= 1'b1;
                        end else if (hdr_op == OP_WRITE || (hdr_op == OP_SPECIAL
                                     && f_mode(hdr_addr, lorg) == MODE_FILL)) begin
                            lk_st_ff <= LK_DATA;
                        end else begin
                            lk_st_ff <= LK_DONE;
                        end
                    end
                end
                LK_DATA: begin
                    data_sr_ff <= {data_sr_ff[13:0], i_serial_in};
                    cnt_ff     <= cnt_ff + 5'h01;
                    if (data_last) begin
                        lk_st_ff <= LK_DONE;
                    end
                end
                LK_READ: begin
                    dout_ff <= sel_word[4'hF - rd_idx_ff];
                    if (idx_last) begin
                        rd_idx_ff <= 4'h0;
                        rd_ptr_ff <= nxt_rd_ptr;
                    end else begin
                        rd_idx_ff <= rd_idx_ff + 4'h1;
                    end
                end
                LK_DONE: begin
                    lk_st_ff <= LK_DONE;
                end
                default: begin
                    lk_st_ff <= LK_IDLE;
                end
            endcase
        end
    end

    // Command fields survive deselect; the core reads them after the toggle crosses
    always_ff @(posedge i_serial_shift_clock or posedge link_rst_ff) begin
        if (link_rst_ff) begin
            cmd_tgl_ff  <= 1'b0;
            cmd_op_ff   <= 2'h0;
            cmd_addr_ff <= 11'h000;
            cmd_data_ff <= 16'h0000;
            cmd_org_ff  <= 1'b1;
        end else if (i_chip_select) begin
            if (lk_st_ff == LK_HDR && hdr_last && hdr_op != OP_READ) begin
                cmd_op_ff   <= hdr_op;
                cmd_addr_ff <= hdr_addr;
                cmd_org_ff  <= lorg;
                if (!(hdr_op == OP_WRITE || (hdr_op == OP_SPECIAL
                      && f_mode(hdr_addr, lorg) == MODE_FILL))) begin
                    cmd_tgl_ff <= ~cmd_tgl_ff;
                end
            end else if (lk_st_ff == LK_DATA && data_last) begin
                cmd_data_ff <= lorg ? {data_sr_ff, i_serial_in}
                                    : {8'h00, data_sr_ff[6:0], i_serial_in};
                cmd_tgl_ff  <= ~cmd_tgl_ff;
            end
        end
    end

    // ---------------- Core domain (i_clock) ----------------
    sec_core_st_t       co_st_ff;
    logic [4:0]         sync1_ff;
    logic [4:0]         sync2_ff;
    logic               tgl_prev_ff;
    logic               tgl_sync1_ff;
    logic               tgl_sync2_ff;
    logic               enable_ff;
    logic               status_show_ff;
    logic [31:0]        timer_ff;
    logic               fill_run_ff;
    logic [WADDR_W-1:0] fill_idx_ff;
    logic               wr_en_ff;
    logic [WADDR_W-1:0] wr_addr_ff;
    logic [1:0]         wr_be_ff;
    logic [WORD_W-1:0]  wr_data_ff;
    logic               cs_s;
    logic               wp_s;
    logic               rd_act_s;
    logic               rd_bit_s;
    logic               started_s;
    logic               cmd_edge;
    logic [1:0]         cmd_mode;
    logic               cmd_is_prog;
    logic               cmd_is_all;
    logic               start_go;
    logic [WORD_W-1:0]  pattern;

    assign cs_s      = sync2_ff[0];
    assign wp_s      = sync2_ff[1];
    assign rd_act_s  = sync2_ff[2];
    assign rd_bit_s  = sync2_ff[3];
    assign started_s = sync2_ff[4];
    assign cmd_edge  = tgl_sync2_ff ^ tgl_prev_ff;
    assign cmd_mode  = f_mode(cmd_addr_ff, cmd_org_ff);
    assign cmd_is_all  = (cmd_op_ff == OP_SPECIAL)
                       && (cmd_mode == MODE_FILL || cmd_mode == MODE_CLEAR);
    assign cmd_is_prog = (cmd_op_ff == OP_WRITE) || (cmd_op_ff == OP_ERASE) || cmd_is_all;
    assign start_go  = (co_st_ff == CO_ARMED) && !cs_s && enable_ff && wp_s;
    assign pattern   = (cmd_op_ff == OP_ERASE || cmd_mode == MODE_CLEAR) ? ERASED_WORD :
                       cmd_org_ff ? cmd_data_ff : {cmd_data_ff[7:0], cmd_data_ff[7:0]};

    always_ff @(posedge i_clock) begin
        link_rst_ff  <= i_srst;
        sync1_ff     <= {started_ff, dout_ff, rd_act_ff, i_write_protect_n, i_chip_select};
        sync2_ff     <= sync1_ff;
        tgl_sync1_ff <= cmd_tgl_ff;
        tgl_sync2_ff <= tgl_sync1_ff;
        tgl_prev_ff  <= tgl_sync2_ff;
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            enable_ff <= 1'b0;
        end else if (cmd_edge && co_st_ff == CO_IDLE && cmd_op_ff == OP_SPECIAL) begin
            if (cmd_mode == MODE_ENABLE) begin
                enable_ff <= 1'b1;
            end else if (cmd_mode == MODE_DISABLE) begin
                enable_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            co_st_ff <= CO_IDLE;
            timer_ff <= 32'h0000_0000;
        end else begin
            case (co_st_ff)
                CO_IDLE: begin
                    if (cmd_edge && cmd_is_prog) begin
                        co_st_ff <= CO_ARMED;
                    end
                end
                CO_ARMED: begin
                    // Programming starts on deselect; refused commands are dropped
                    if (start_go) begin
                        co_st_ff <= CO_BUSY;
                        timer_ff <= 32'(PROG_CYCLES_P);
                    end else if (!cs_s) begin
                        co_st_ff <= CO_IDLE;
                    end
                end
                CO_BUSY: begin
                    // Select is not looked at here: the cycle always completes
                    if (timer_ff == 32'h0000_0001) begin
                        co_st_ff <= CO_IDLE;
                    end
                    timer_ff <= timer_ff - 32'h0000_0001;
                end
                default: begin
                    co_st_ff <= CO_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            fill_run_ff <= 1'b0;
            fill_idx_ff <= 10'h000;
            wr_en_ff    <= 1'b0;
            wr_addr_ff  <= 10'h000;
            wr_be_ff    <= 2'h0;
            wr_data_ff  <= 16'h0000;
        end else if (start_go && !cmd_is_all) begin
            wr_en_ff   <= 1'b1;
            wr_addr_ff <= cmd_org_ff ? cmd_addr_ff[9:0] : cmd_addr_ff[10:1];
            wr_be_ff   <= cmd_org_ff ? 2'h3 : (cmd_addr_ff[0] ? 2'h1 : 2'h2);
            wr_data_ff <= pattern;
        end else if (start_go || fill_run_ff) begin
            fill_run_ff <= start_go || (fill_idx_ff != LAST_WADDR);
            fill_idx_ff <= start_go ? 10'h000 : fill_idx_ff + 10'h001;
            wr_en_ff    <= fill_run_ff;
            wr_addr_ff  <= fill_idx_ff;
            wr_be_ff    <= 2'h3;
            wr_data_ff  <= pattern;
        end else begin
            wr_en_ff <= 1'b0;
        end
    end

    // Set on entry wins over the clear by a new start bit
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            status_show_ff <= 1'b0;
        end else if (start_go) begin
            status_show_ff <= 1'b1;
        end else if (started_s && cs_s) begin
            status_show_ff <= 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_serial_out      <= 1'b0;
            o_serial_out_en   <= 1'b0;
            o_busy            <= 1'b0;
            o_standby         <= 1'b1;
            o_program_enabled <= 1'b0;
        end else begin
            o_serial_out      <= rd_act_s ? rd_bit_s : (co_st_ff != CO_BUSY);
            o_serial_out_en   <= cs_s && (rd_act_s || status_show_ff);
            o_busy            <= (co_st_ff == CO_BUSY);
            o_standby         <= !cs_s && (co_st_ff != CO_BUSY);
            o_program_enabled <= enable_ff;
        end
    end

    sec_mem #(
        .WIDTH (WORD_W),
        .DEPTH (MEM_DEPTH),
        .AW    (WADDR_W)
    ) u_mem (
        .i_wr_clock (i_clock),
        .i_wr_en    (wr_en_ff),
        .i_wr_addr  (wr_addr_ff),
        .i_wr_be    (wr_be_ff),
        .i_wr_data  (wr_data_ff),
        .i_rd_clock (i_serial_shift_clock),
        .i_rd_en    (mem_rd_en),
        .i_rd_addr  (lorg ? nxt_rd_ptr[9:0] : nxt_rd_ptr[10:1]),
        .o_rd_data  (rd_q)
    );

    sequence seq_armed_ok;
        (co_st_ff == CO_ARMED) && !cs_s && enable_ff && wp_s;
    endsequence

    chk_oe_deselect: assert property (@(posedge i_clock) disable iff (i_srst)
        !cs_s |=> !o_serial_out_en) else $error("output driven while deselected");
    chk_busy_holds: assert property (@(posedge i_clock) disable iff (i_srst)
        (co_st_ff == CO_BUSY) && timer_ff > 32'h1 |=> co_st_ff == CO_BUSY)
        else $error("programming cut short");
    chk_standby_late: assert property (@(posedge i_clock) disable iff (i_srst)
        (co_st_ff == CO_BUSY) |=> !o_standby) else $error("standby during programming");
    chk_protect_block: assert property (@(posedge i_clock) disable iff (i_srst)
        (co_st_ff == CO_ARMED) && !wp_s |=> co_st_ff != CO_BUSY)
        else $error("programming while protected");
    chk_need_enable: assert property (@(posedge i_clock) disable iff (i_srst)
        (co_st_ff == CO_ARMED) && !enable_ff |=> co_st_ff != CO_BUSY)
        else $error("programming while disabled");
    chk_start_prog: assert property (@(posedge i_clock) disable iff (i_srst)
        seq_armed_ok |=> (co_st_ff == CO_BUSY) ##1 o_busy)
        else $error("allowed programming did not start");
    chk_status_low: assert property (@(posedge i_clock) disable iff (i_srst)
        (co_st_ff == CO_BUSY) && !rd_act_s |=> !o_serial_out)
        else $error("status not low while busy");
    chk_enable_cmd: assert property (@(posedge i_clock) disable iff (i_srst)
        cmd_edge && co_st_ff == CO_IDLE && cmd_op_ff == OP_SPECIAL
        && cmd_mode == MODE_ENABLE |=> enable_ff ##1 o_program_enabled)
        else $error("enable command not taken");
    chk_dummy_zero: assert property (@(posedge i_serial_shift_clock) disable iff (frame_rst)
        (lk_st_ff == LK_HDR) && hdr_last && hdr_op == OP_READ |=> !dout_ff && rd_act_ff)
        else $error("no leading zero on read");
endmodule : sec_command_port

// ===== verif/sec_master.sv
// Serial bus master model driving select, shift clock and serial input
`timescale 1ns/1ps
module sec_master (
    output logic      o_sclk,
    output logic      o_cs,
    output logic      o_di,
    input  wire logic i_so
);
    initial begin
        o_sclk = 1'b0;
        o_cs   = 1'b0;
        o_di   = 1'b0;
    end

    // Clock runs only inside frames; inputs change after the falling edge
    task automatic xfer(input logic [63:0] bits, input int n, output logic [63:0] rx);
        rx = '0;
        #7.3;
        o_cs = 1'b1;
        for (int k = n - 1; k >= 0; k--) begin
            o_di = bits[k];
            #15;
            rx = {rx[62:0], i_so};
            o_sclk = 1'b1;
            #15;
            o_sclk = 1'b0;
        end
        #15;
        rx = {rx[62:0], i_so};
    endtask : xfer

    // Released input shows the inverse so a stale level cannot pass for data
    task automatic deselect();
        o_cs = 1'b0;
        o_di = ~o_di;
        #40;
    endtask : deselect

    task automatic select();
        o_cs = 1'b1;
        #40;
    endtask : select
endmodule : sec_master

// ===== verif/testbench.sv
// Self-checking bench of the serial EEPROM command port
`timescale 1ns/1ps
module testbench;
    import sec_pkg::*;
    localparam int PROG = 2000;
    logic        i_clock, i_srst, i_write_protect_n, i_word_width_select;
    wire logic   sclk, cs, di;
    logic        o_serial_out, o_serial_out_en, o_busy, o_standby, o_program_enabled;
    logic [63:0] rx;
    logic [15:0] model [0:1023];
    logic [9:0]  a;
    int          failures, cmp_count, timer;

    sec_master m_u (.o_sclk(sclk), .o_cs(cs), .o_di(di), .i_so(o_serial_out));
    sec_command_port #(.PROG_CYCLES_P(PROG)) dut_u (
        .i_clock(i_clock), .i_srst(i_srst), .i_serial_shift_clock(sclk),
        .i_chip_select(cs), .i_serial_in(di), .i_write_protect_n(i_write_protect_n),
        .i_word_width_select(i_word_width_select), .o_serial_out(o_serial_out),
        .o_serial_out_en(o_serial_out_en), .o_busy(o_busy), .o_standby(o_standby),
        .o_program_enabled(o_program_enabled));

    always #2.5 i_clock = ~i_clock;

    function automatic logic [12:0] hdr(input logic [1:0] op, input logic [9:0] ad);
        return {1'b1, op, ad};
    endfunction : hdr

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clock);
    endtask : cyc

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic give_verdict();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict

    // Frame, deselect, then follow the status phase to the end of the cycle
    task automatic prog(input logic [63:0] bits, input int n, input logic go);
        logic [63:0] r;
        m_u.xfer(bits, n, r);
        m_u.deselect();
        cyc(8);
        check("busy", go, o_busy);
        if (go) begin
            check("standby_busy", 0, o_standby);
            m_u.select();
            cyc(8);
            check("status_en", 1, o_serial_out_en);
            check("status_busy", 0, o_serial_out);
            for (int i = 0; i < PROG + 500 && o_busy !== 1'b0; i++) cyc(1);
            cyc(8);
            check("status_ready", 1, o_serial_out);
            m_u.deselect();
            cyc(8);
            check("standby", 1, o_standby);
            check("released", 0, o_serial_out_en);
        end
    endtask : prog

    task automatic wr(input logic [9:0] ad, input logic [15:0] d, input logic go);
        prog({2'b00, hdr(OP_WRITE, ad), d}, 31, go);
        if (go) model[ad] = d;
    endtask : wr

    task automatic special(input logic [1:0] mode);
        m_u.xfer({2'b00, hdr(OP_SPECIAL, {mode, 8'h00})}, 15, rx);
        m_u.deselect();
        cyc(8);
    endtask : special

    // Two words streamed from one instruction, the second from the next address
    task automatic rd(input logic [9:0] ad);
        logic [9:0] nx;
        nx = ad + 10'h001;
        m_u.xfer({2'b00, hdr(OP_READ, ad), 32'h0}, 47, rx);
        check("dummy", 0, rx[32]);
        check("word", model[ad], rx[31:16]);
        check("next_word", model[nx], rx[15:0]);
        m_u.deselect();
    endtask : rd

    always @(posedge i_clock) begin
        timer++;
        if (timer == 60000) begin
            failures++;
            give_verdict();
        end
    end

    initial begin
        i_clock = 1'b0;
        i_srst = 1'b1;
        i_write_protect_n = 1'b1;
        i_word_width_select = 1'b1;
        void'($urandom(3068));
        cyc(16);
        i_srst <= 1'b0;
        cyc(4);
        check("reset_standby", 1, o_standby);
        check("reset_enabled", 0, o_program_enabled);
        wr(10'h005, 16'h1234, 1'b0);
        special(MODE_ENABLE);
        check("enabled", 1, o_program_enabled);
        $display("test reset_enable done");
        prog({2'b00, hdr(OP_SPECIAL, {MODE_CLEAR, 8'h00})}, 15, 1'b1);
        foreach (model[i]) model[i] = ERASED_WORD;
        for (int t = 0; t < 4; t++) begin
            a = (t == 0) ? LAST_WADDR : 10'($urandom);
            wr(a, 16'($urandom), 1'b1);
            rd(a);
        end
        $display("test random_write done");
        prog({2'b00, hdr(OP_ERASE, a)}, 15, 1'b1);
        model[a] = ERASED_WORD;
        rd(a);
        @(posedge i_clock) i_write_protect_n <= 1'b0;
        cyc(4);
        wr(a, 16'hA5A5, 1'b0);
        rd(a);
        @(posedge i_clock) i_write_protect_n <= 1'b1;
        $display("test erase_protect done");
        prog({2'b00, hdr(OP_SPECIAL, {MODE_FILL, 8'h00}), 16'h5AC3}, 31, 1'b1);
        foreach (model[i]) model[i] = 16'h5AC3;
        rd(10'($urandom));
        special(MODE_DISABLE);
        check("disabled", 0, o_program_enabled);
        wr(10'h005, 16'h0F0F, 1'b0);
        rd(10'h005);
        $display("test fill_disable done");
        @(posedge i_clock) i_word_width_select <= 1'b0;
        cyc(4);
        m_u.xfer({2'b00, 1'b1, OP_SPECIAL, MODE_ENABLE, 9'h000}, 16, rx);
        m_u.deselect();
        cyc(8);
        check("byte_enabled", 1, o_program_enabled);
        prog({2'b00, 1'b1, OP_WRITE, 11'h00A, 8'h3C}, 24, 1'b1);
        model[5] = {8'h3C, model[5][7:0]};
        m_u.xfer({2'b00, 1'b1, OP_READ, 11'h00A, 16'h0000}, 32, rx);
        check("byte_dummy", 0, rx[16]);
        check("byte_pair", model[5], rx[15:0]);
        m_u.deselect();
        $display("test byte_mode done");
        give_verdict();
    end
endmodule : testbench
